// [rtl/lock_pkg.sv]
package lock_pkg;

  // clocking and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 10000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // register map, byte offsets on the plain register port
  localparam logic [7:0] FAULT_CONFIG_ONE_OFS = 8'h90;
  localparam logic [7:0] LOCK_STATUS_OFS      = 8'hA0;
  localparam logic [7:0] LOCK_MASK_OFS        = 8'hA4;
  localparam logic [7:0] LOCK_STATE_OFS       = 8'hA8;

  localparam logic [31:0] FAULT_CONFIG_ONE_RST = 32'h0000_0000;
  localparam logic [3:0]  LOCK_STATUS_RST      = 4'h0;
  localparam logic [3:0]  LOCK_MASK_RST        = 4'h0;

  // field positions of fault_config_one
  localparam int unsigned PARITY_POS          = 31;
  localparam int unsigned TORQUE_REF_LSB      = 27;
  localparam int unsigned COMP_THRESH_LSB     = 23;
  localparam int unsigned ADC_THRESH_LSB      = 19;
  localparam int unsigned LOCK_MODE_LSB       = 15;
  localparam int unsigned DEGLITCH_LSB        = 11;
  localparam int unsigned RETRY_TIME_LSB      = 7;
  localparam int unsigned MOTOR_LOCK_MODE_LSB = 3;

  typedef struct packed {
    logic       parity;
    logic [3:0] torque_current_ref;
    logic [3:0] comparator_lock_threshold;
    logic [3:0] adc_lock_threshold;
    logic [3:0] lock_response_mode;
    logic [3:0] lock_deglitch_select;
    logic [3:0] lock_retry_time;
    logic [3:0] motor_lock_mode;
    logic       timeout_fault_en;
    logic       freq_fault_en;
    logic       saturation_flags_en;
  } fault_cfg_s;

  // status / mask bit positions
  localparam int unsigned ST_COMP_LOCK = 0;
  localparam int unsigned ST_ADC_LOCK  = 1;
  localparam int unsigned ST_LATCHED   = 2;
  localparam int unsigned ST_RETRY     = 3;

  // response mode codes
  localparam logic [3:0] MODE_RETRY_FIRST = 4'h4;
  localparam logic [3:0] MODE_REPORT      = 4'h8;

  typedef enum logic [1:0] {
    DRIVE_TRISTATE,
    DRIVE_RECIRCULATE,
    DRIVE_HIGH_BRAKE,
    DRIVE_LOW_BRAKE
  } drive_action_e;

  typedef enum logic [1:0] {
    ST_MONITOR,
    ST_RETRY_WAIT,
    ST_FAULT_LATCHED
  } lock_state_e;

  localparam int unsigned MA_W   = 14;
  localparam int unsigned TICK_W = 17;

  // current code to milliamps, shared by all three current fields
  function automatic logic [MA_W-1:0] current_ma(input logic [3:0] code);
    logic [MA_W-1:0] ma;
    ma = 14'h0000;
    unique case (code)
      4'h0: ma = 14'h007D;
      4'h1: ma = 14'h00FA;
      4'h2: ma = 14'h01F4;
      4'hE: ma = 14'h1B58;
      4'hF: ma = 14'h1F40;
      default: ma = 14'h03E8 + 14'(code - 4'h3) * 14'h01F4;
    endcase
    return ma;
  endfunction

  // deglitch time in 10 us ticks: 0.05 ms .. 1000 ms
  function automatic logic [TICK_W-1:0] deglitch_ticks(input logic [3:0] code);
    logic [TICK_W-1:0] t;
    t = 17'h00000;
    unique case (code)
      4'h0: t = 17'h00005;
      4'h1: t = 17'h0000A;
      4'h2: t = 17'h00014;
      4'h3: t = 17'h00032;
      4'h4: t = 17'h00064;
      4'h5: t = 17'h000FA;
      4'h6: t = 17'h001F4;
      4'h7: t = 17'h002EE;
      4'h8: t = 17'h003E8;
      4'h9: t = 17'h009C4;
      4'hA: t = 17'h01388;
      4'hB: t = 17'h01D4C;
      4'hC: t = 17'h02710;
      4'hD: t = 17'h04E20;
      4'hE: t = 17'h0C350;
      4'hF: t = 17'h186A0;
    endcase
    return t;
  endfunction

endpackage

// [rtl/lock_compare.sv]
`timescale 1ns/100ps
`default_nettype none

module lock_compare #(
  parameter int unsigned W = 14
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] current_i,
  input  wire logic [W-1:0] threshold_i,
  output logic              over_o
);

  initial begin
    if (W < 14) $error("lock_compare: W too small for 8 A in mA");
  end

  logic next_over;

  always_comb begin
    next_over = current_i > threshold_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      over_o <= 1'b0;
    end else begin
      over_o <= next_over;
    end
  end

endmodule

`default_nettype wire

// [rtl/lock_deglitch.sv]
`timescale 1ns/100ps
`default_nettype none

module lock_deglitch (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cond_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] select_i,
  output logic            confirmed_o
);

  logic [lock_pkg::TICK_W-1:0] count;
  logic [lock_pkg::TICK_W-1:0] next_count;
  logic                        next_confirmed;

  // the first partial tick counts whole, so the wait may be short
  // by up to one tick; acceptable against 50 us minimum
  always_comb begin
    next_count     = count;
    next_confirmed = confirmed_o;
    if (!cond_i) begin
      next_count     = '0;
      next_confirmed = 1'b0;
    end else if (count >= lock_pkg::deglitch_ticks(select_i)) begin
      next_confirmed = 1'b1;
    end else if (tick_i) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count       <= '0;
      confirmed_o <= 1'b0;
    end else begin
      count       <= next_count;
      confirmed_o <= next_confirmed;
    end
  end

endmodule

`default_nettype wire

// [rtl/lock_current_limit_config.sv]
`timescale 1ns/100ps
`default_nettype none

module lock_current_limit_config #(
  parameter int unsigned TICK_CYCLES       = lock_pkg::TICK_CYCLES,
  parameter int unsigned RETRY_STEP_TICKS  = 10000,
  parameter int unsigned RETRY_LIMIT       = 3
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [31:0]                    reg_rdata_o,
  input  wire logic [lock_pkg::MA_W-1:0] comp_current_ma_i,
  input  wire logic [lock_pkg::MA_W-1:0] adc_current_ma_i,
  output logic [lock_pkg::MA_W-1:0]      torque_ref_ma_o,
  output logic [lock_pkg::MA_W-1:0]      comparator_limit_ma_o,
  output logic [lock_pkg::MA_W-1:0]      adc_threshold_ma_o,
  output lock_pkg::drive_action_e        drive_action_o,
  output logic                           drive_override_o,
  output logic                           fault_indicator_n_o,
  output logic                           irq_o
);

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
      $error("TICK_CYCLES out of range");
    if (RETRY_STEP_TICKS < 1 || RETRY_STEP_TICKS > 65535)
      $error("RETRY_STEP_TICKS out of range");
    if (RETRY_LIMIT < 1 || RETRY_LIMIT > 15)
      $error("RETRY_LIMIT out of range");
  end

  localparam logic [15:0] TICK_LAST  = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] RETRY_STEP = 16'(RETRY_STEP_TICKS);
  localparam logic [3:0]  RETRY_MAX  = 4'(RETRY_LIMIT);

  // register file
  logic [31:0]          cfg_word;
  logic [31:0]          next_cfg_word;
  logic [3:0]           status;
  logic [3:0]           next_status;
  logic [3:0]           mask;
  logic [3:0]           next_mask;
  logic [31:0]          next_rdata;
  logic                 next_irq;
  lock_pkg::fault_cfg_s cfg;
  logic [3:0]           status_set;
  logic [3:0]           status_clr;

  assign cfg = lock_pkg::fault_cfg_s'(cfg_word);

  // lock engine
  lock_pkg::lock_state_e   state;
  lock_pkg::lock_state_e   next_state;
  lock_pkg::drive_action_e next_action;
  logic [15:0]             tick_cnt;
  logic [15:0]             next_tick_cnt;
  logic                    tick;
  logic [19:0]             retry_cnt;
  logic [19:0]             next_retry_cnt;
  logic [3:0]              retries;
  logic [3:0]              next_retries;
  logic                    confirmed_q;
  logic                    next_confirmed_q;
  logic                    next_override;
  logic                    next_fault_n;
  logic [lock_pkg::MA_W-1:0] next_torque_ma;
  logic [lock_pkg::MA_W-1:0] next_comp_ma;
  logic [lock_pkg::MA_W-1:0] next_adc_ma;

  logic comp_over;
  logic adc_over;
  logic detect_on;
  logic lock_raw;
  logic confirmed;
  logic lock_event;
  logic is_latch_mode;
  logic is_retry_mode;
  logic is_report_mode;

  always_comb begin
    is_latch_mode  = cfg.lock_response_mode < lock_pkg::MODE_RETRY_FIRST;
    is_retry_mode  = !is_latch_mode &&
                     cfg.lock_response_mode < lock_pkg::MODE_REPORT;
    is_report_mode = cfg.lock_response_mode == lock_pkg::MODE_REPORT;
    detect_on      = cfg.lock_response_mode <= lock_pkg::MODE_REPORT;
    // comparator and adc paths share one deglitch; either one over its limit counts
    lock_raw       = detect_on && (state == lock_pkg::ST_MONITOR) &&
                     (comp_over || adc_over);
    lock_event     = confirmed && !confirmed_q;
  end

  lock_compare #(
    .W(lock_pkg::MA_W)
  ) u_comp_cmp (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .current_i  (comp_current_ma_i),
    .threshold_i(comparator_limit_ma_o),
    .over_o     (comp_over)
  );

  lock_compare #(
    .W(lock_pkg::MA_W)
  ) u_adc_cmp (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .current_i  (adc_current_ma_i),
    .threshold_i(adc_threshold_ma_o),
    .over_o     (adc_over)
  );

  lock_deglitch u_deglitch (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .cond_i     (lock_raw),
    .tick_i     (tick),
    .select_i   (cfg.lock_deglitch_select),
    .confirmed_o(confirmed)
  );

  // register port
  always_comb begin
    next_cfg_word = cfg_word;
    next_mask     = mask;
    status_clr    = 4'h0;
    next_rdata    = 32'h0000_0000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        lock_pkg::FAULT_CONFIG_ONE_OFS: next_cfg_word = reg_wdata_i;
        lock_pkg::LOCK_STATUS_OFS:      status_clr    = reg_wdata_i[3:0];
        lock_pkg::LOCK_MASK_OFS:        next_mask     = reg_wdata_i[3:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        lock_pkg::FAULT_CONFIG_ONE_OFS: next_rdata = cfg_word;
        lock_pkg::LOCK_STATUS_OFS:      next_rdata = {28'h0, status};
        lock_pkg::LOCK_MASK_OFS:        next_rdata = {28'h0, mask};
        lock_pkg::LOCK_STATE_OFS:
          next_rdata = {24'h0, retries, 2'h0, state};
        default: ;
      endcase
    end
    // a set in the same cycle as its clear wins
    next_status = (status & ~status_clr) | status_set;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_word    <= lock_pkg::FAULT_CONFIG_ONE_RST;
      status      <= lock_pkg::LOCK_STATUS_RST;
      mask        <= lock_pkg::LOCK_MASK_RST;
      reg_rdata_o <= 32'h0000_0000;
      irq_o       <= 1'b0;
    end else begin
      cfg_word    <= next_cfg_word;
      status      <= next_status;
      mask        <= next_mask;
      reg_rdata_o <= next_rdata;
      irq_o       <= next_irq;
    end
  end

  // decoded currents, one cycle behind the config word
  always_comb begin
    next_torque_ma = lock_pkg::current_ma(cfg.torque_current_ref);
    next_comp_ma   =
      lock_pkg::current_ma(cfg.comparator_lock_threshold);
    next_adc_ma    = lock_pkg::current_ma(cfg.adc_lock_threshold);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      torque_ref_ma_o       <= '0;
      comparator_limit_ma_o <= '0;
      adc_threshold_ma_o    <= '0;
    end else begin
      torque_ref_ma_o       <= next_torque_ma;
      comparator_limit_ma_o <= next_comp_ma;
      adc_threshold_ma_o    <= next_adc_ma;
    end
  end

  // free-running 10 us prescaler; it keeps running between locks,
  // which is why the first deglitch tick may be partial
  always_comb begin
    tick          = tick_cnt == TICK_LAST;
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // lock response state machine
  always_comb begin
    next_state       = state;
    next_retry_cnt   = retry_cnt;
    next_retries     = retries;
    next_action      = drive_action_o;
    next_override    = drive_override_o;
    // rising edge only, so a standing lock in report mode reports once
    next_confirmed_q = confirmed;
    status_set       = 4'h0;
    if (lock_event) begin
      status_set[lock_pkg::ST_COMP_LOCK] = comp_over;
      status_set[lock_pkg::ST_ADC_LOCK]  = adc_over;
    end
    unique case (state)
      lock_pkg::ST_MONITOR: begin
        next_override = 1'b0;
        if (lock_event && !is_report_mode) begin
          next_action = lock_pkg::drive_action_e'(cfg.lock_response_mode[1:0]);
          next_override = 1'b1;
          if (is_latch_mode || (is_retry_mode && retries >= RETRY_MAX)) begin
            next_state = lock_pkg::ST_FAULT_LATCHED;
            status_set[lock_pkg::ST_LATCHED] = 1'b1;
          end else begin
            next_state     = lock_pkg::ST_RETRY_WAIT;
            next_retry_cnt = 20'(RETRY_STEP) *
                             20'(cfg.lock_retry_time + 5'h01);
            next_retries   = retries + 1'b1;
            status_set[lock_pkg::ST_RETRY] = 1'b1;
          end
        end
      end
      lock_pkg::ST_RETRY_WAIT: begin
        // retry delay scales with lock_retry_time, one step per code
        if (retry_cnt == 20'h00000) begin
          next_state    = lock_pkg::ST_MONITOR;
          next_override = 1'b0;
        end else if (tick) begin
          next_retry_cnt = retry_cnt - 1'b1;
        end
      end
      lock_pkg::ST_FAULT_LATCHED: begin
        // leaves only when software clears the latched status bit
        if (status_clr[lock_pkg::ST_LATCHED]) begin
          next_state    = lock_pkg::ST_MONITOR;
          next_override = 1'b0;
          next_retries  = 4'h0;
        end
      end
    endcase
    // indicator stays low until software clears the cause
    next_fault_n = !(next_state != lock_pkg::ST_MONITOR ||
                     next_status[lock_pkg::ST_COMP_LOCK] ||
                     next_status[lock_pkg::ST_ADC_LOCK]);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state               <= lock_pkg::ST_MONITOR;
      retry_cnt           <= 20'h00000;
      retries             <= 4'h0;
      confirmed_q         <= 1'b0;
      drive_action_o      <= lock_pkg::DRIVE_TRISTATE;
      drive_override_o    <= 1'b0;
      fault_indicator_n_o <= 1'b1;
    end else begin
      state               <= next_state;
      retry_cnt           <= next_retry_cnt;
      retries             <= next_retries;
      confirmed_q         <= next_confirmed_q;
      drive_action_o      <= next_action;
      drive_override_o    <= next_override;
      fault_indicator_n_o <= next_fault_n;
    end
  end

endmodule

`default_nettype wire

// [bench/lock_limit_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module lock_limit_properties #(
  parameter int unsigned TICK_CYCLES = 2
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [31:0]             reg_rdata_o,
  input  wire logic [13:0]             comp_current_ma_i,
  input  wire logic [13:0]             adc_current_ma_i,
  input  wire logic [13:0]             torque_ref_ma_o,
  input  wire logic [13:0]             comparator_limit_ma_o,
  input  wire logic [13:0]             adc_threshold_ma_o,
  input  wire lock_pkg::drive_action_e drive_action_o,
  input  wire logic                    drive_override_o,
  input  wire logic                    fault_indicator_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [31:0] cfg;
  logic [15:0] run;
  logic        wr90;
  logic        hi;

  assign wr90 = reg_wr_i && reg_addr_i == 8'h90;
  assign hi   = comp_current_ma_i > comparator_limit_ma_o
             || adc_current_ma_i > adc_threshold_ma_o;

  function automatic logic [13:0] ma(input logic [3:0] c);
    return c < 4'h3 ? 14'h007D << c : c == 4'hE ? 14'h1B58
         : c == 4'hF ? 14'h1F40 : 14'h01F4 * 14'(c) - 14'h01F4;
  endfunction

  // shadow of the config word and length of the current overrun
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg <= 32'h0000_0000;
      run <= 16'h0000;
    end else begin
      if (wr90) begin
        cfg <= reg_wdata_i;
      end
      run <= hi ? run + 16'h0001 : 16'h0000;
    end
  end

  chk_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read slot");
  chk_read_back: assert property (
    wr90 ##1 (reg_rd_i && reg_addr_i == 8'h90)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("config word read back wrong");
  chk_torque_decode: assert property (
    wr90 ##1 !wr90 |=> torque_ref_ma_o == ma($past(reg_wdata_i[30:27], 2)))
    else $error("torque reference decode wrong");
  chk_comp_decode: assert property (
    wr90 ##1 !wr90
    |=> comparator_limit_ma_o == ma($past(reg_wdata_i[26:23], 2)))
    else $error("comparator limit decode wrong");
  chk_adc_decode: assert property (
    wr90 ##1 !wr90
    |=> adc_threshold_ma_o == ma($past(reg_wdata_i[22:19], 2)))
    else $error("adc threshold decode wrong");
  chk_lock_cause: assert property (
    $fell(fault_indicator_n_o) |-> $past(hi, 4))
    else $error("lock flagged without overcurrent");
  chk_deglitch_min: assert property (
    $fell(fault_indicator_n_o) |-> run >= 16'(4 * TICK_CYCLES))
    else $error("lock flagged before deglitch time");
  chk_act_mode: assert property (
    $fell(fault_indicator_n_o) && cfg[18:15] < 4'h8 |-> drive_override_o
      && drive_action_o == lock_pkg::drive_action_e'(cfg[16:15]))
    else $error("lock action wrong for mode");
  chk_report_only: assert property (
    $fell(fault_indicator_n_o) && cfg[18:15] == 4'h8 |-> !drive_override_o)
    else $error("report mode took action");
  chk_lock_off: assert property (
    $fell(fault_indicator_n_o) |-> cfg[18:15] < 4'h9)
    else $error("lock flagged while detection off");
endmodule

bind lock_current_limit_config lock_limit_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .comp_current_ma_i(comp_current_ma_i),
  .adc_current_ma_i(adc_current_ma_i),
  .torque_ref_ma_o(torque_ref_ma_o),
  .comparator_limit_ma_o(comparator_limit_ma_o),
  .adc_threshold_ma_o(adc_threshold_ma_o),
  .drive_action_o(drive_action_o),
  .drive_override_o(drive_override_o),
  .fault_indicator_n_o(fault_indicator_n_o)
);
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                    clk     = 1'b0;
  logic                    rst_n   = 1'b0;
  logic [7:0]              addr    = 8'h00;
  logic [31:0]             wdata   = 32'h0000_0000;
  logic                    wr_s    = 1'b0;
  logic                    rd_s    = 1'b0;
  logic [13:0]             comp_ma = 14'h0000;
  logic [13:0]             adc_ma  = 14'h0000;
  logic [31:0]             rdata;
  logic [13:0]             torque;
  logic [13:0]             climit;
  logic [13:0]             alimit;
  lock_pkg::drive_action_e action;
  logic                    ovr;
  logic                    flt_n;
  logic                    irq;
  int                      fail_count = 0;
  int                      n_compared = 0;
  int                      cycles     = 0;
  int                      seed       = 32'hE6C1;

  always #5 clk = ~clk;

  // short tick and retry step keep the deglitch and retry waits short
  lock_current_limit_config #(
    .TICK_CYCLES(2),
    .RETRY_STEP_TICKS(3),
    .RETRY_LIMIT(8)
  ) DUT (
    .sys_clk_i(clk),
    .rst_n_i(rst_n),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr_s),
    .reg_rd_i(rd_s),
    .reg_rdata_o(rdata),
    .comp_current_ma_i(comp_ma),
    .adc_current_ma_i(adc_ma),
    .torque_ref_ma_o(torque),
    .comparator_limit_ma_o(climit),
    .adc_threshold_ma_o(alimit),
    .drive_action_o(action),
    .drive_override_o(ovr),
    .fault_indicator_n_o(flt_n),
    .irq_o(irq)
  );

  function automatic logic [31:0] amps(input int c);
    return c < 3 ? 125 << c : c == 14 ? 7000 : c == 15 ? 8000 : 500 * c - 500;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // caller follows with rd or cyc, never a second wr in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] d;
    logic [31:0] w;
    logic [3:0]  msk;
    logic [3:0]  st;
    int          n;
    int          lo;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    rd(8'h90, d);
    check(d, 32'h0000_0000);
    check(torque, amps(0));
    for (int k = 0; k < 16; k++) begin
      w = $random(seed);
      w[30:27] = 4'(k);
      w[26:23] = 4'(15 - k);
      w[22:19] = 4'(k + 7);
      w[18:15] = 4'h9;
      comp_ma <= 14'($random(seed));
      wr(8'h90, w);
      rd(8'h90, d);
      check(d, w);
      check(torque, amps(k));
      check(climit, amps(15 - k));
      check(alimit, amps((k + 7) % 16));
      check(flt_n, 1'b1);
    end
    wr(8'h94, 32'hFFFF_FFFF);
    rd(8'h94, d);
    check(d, 32'h0000_0000);
    rd(8'h90, d);
    check(d, w);
    comp_ma <= 14'h0000;
    // every response code, comparator and adc paths alternating every two codes
    for (int m = 0; m < 16; m++) begin
      w = 32'h0000_0000;
      w[18:15] = 4'(m);
      w[11] = m[0];
      wr(8'h90, w);
      cyc(1);
      msk = 4'($random(seed));
      wr(8'hA4, {28'h0, msk});
      cyc(3);
      if (m[1]) begin
        adc_ma <= 14'h0100;
      end else begin
        comp_ma <= 14'h0100;
      end
      n = 0;
      while (flt_n !== 1'b0 && n < 40) begin
        @(posedge clk);
        n++;
      end
      lo = 10 * (m[0] + 1);
      check(n >= lo - 2 && n <= lo + 4, m < 9);
      if (m < 8) begin
        check(ovr, 1'b1);
        check(action, m % 4);
      end
      if (m == 8) begin
        check(ovr, 1'b0);
      end
      st = (m[1] ? 4'h2 : 4'h1) | (m < 4 ? 4'h4 : m < 8 ? 4'h8 : 4'h0);
      st = m > 8 ? 4'h0 : st;
      @(posedge clk);
      check(irq, |(st & msk));
      comp_ma <= 14'h0000;
      adc_ma <= 14'h0000;
      rd(8'hA0, d);
      check(d, st);
      cyc(20);
      wr(8'hA0, 32'h0000_000F);
      cyc(3);
      check(flt_n, 1'b1);
      check(ovr, 1'b0);
      check(irq, 1'b0);
    end
    // four retries are already counted; four more, then the limit latches
    w = 32'h0000_0000;
    w[18:15] = 4'h4;
    wr(8'h90, w);
    cyc(1);
    comp_ma <= 14'h0100;
    cyc(200);
    comp_ma <= 14'h0000;
    cyc(2);
    check(ovr, 1'b1);
    check(action, 0);
    rd(8'hA8, d);
    check(d, 32'h0000_0082);
    rd(8'hA0, d);
    check(d, 32'h0000_000D);
    wr(8'hA0, 32'h0000_000F);
    cyc(3);
    rd(8'hA8, d);
    check(d, 32'h0000_0000);
    check(flt_n, 1'b1);
    wr(8'h90, 32'h7FFF_FFFF);
    cyc(1);
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(2);
    rd(8'h90, d);
    check(d, 32'h0000_0000);
    check(climit, amps(0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
